// file: shared/cpes_cfg.svh
// Constants for the counter pin edge select block
`ifndef CPES_CFG_SVH
`define CPES_CFG_SVH
`define CPES_ADDR_MODE 4'h0
`define CPES_ADDR_STATUS 4'h1
`define CPES_ADDR_MASK 4'h2
`define CPES_ADDR_COUNT_A 4'h3
`define CPES_ADDR_COUNT_B 4'h4
`define CPES_ADDR_WIDTH_A 4'h5
`define CPES_ADDR_WIDTH_B 4'h6
`define CPES_ADDR_HALF 4'h7
`define CPES_MODE_TIMER 2'h0
`define CPES_MODE_PULSE 2'h1
`define CPES_MODE_EVENT 2'h2
`define CPES_MODE_WIDTH 2'h3
`define CPES_MODE_RESET 8'h00
`define CPES_HALF_RESET 16'h0010
`define CPES_ZERO16 16'h0000
`define CPES_ONE16 16'h0001
`define CPES_ZERO8 8'h00
`define CPES_ZERO2 2'h0
`define CPES_ZERO14 14'h0000
`define CPES_CHAN_STRIDE 4
`define CPES_EDGE_POS 2
`define CPES_MODE_A 1:0
`define CPES_EDGE_A 2
`define CPES_MODE_B 5:4
`define CPES_EDGE_B 6
`endif

// file: shared/cpes_pkg.sv
// Types for the counter pin edge select block
package cpes_pkg;
	typedef logic [1:0] cpes_mode_t;
endpackage

// file: src/cpes_channel.sv
// One timer channel: pin edges, pulse output, event count, width timing
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpes_cfg.svh"
module cpes_channel (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire cpes_pkg::cpes_mode_t i_mode,
	input wire logic i_edge_sel,
	input wire logic i_pin,
	input wire logic [15:0] i_half,
	output logic o_irq_event,
	output logic o_pulse,
	output logic [15:0] o_count,
	output logic [15:0] o_width
);
	logic pin_q;
	logic pulse;
	logic [15:0] tick;
	logic [15:0] count;
	logic [15:0] width;
	logic [15:0] run;
	logic next_pin_q;
	logic next_pulse;
	logic [15:0] next_tick;
	logic [15:0] next_count;
	logic [15:0] next_width;
	logic [15:0] next_run;
	logic next_irq;
	logic rise;
	logic fall;
	logic prev_mode_pulse;
	logic next_prev_mode_pulse;

	always_comb begin
		rise = i_pin & ~pin_q;
		fall = ~i_pin & pin_q;
		next_pin_q = i_pin;
		next_pulse = pulse;
		next_tick = tick;
		next_count = count;
		next_width = width;
		next_run = run;
		next_irq = 1'b0;
		next_prev_mode_pulse = (i_mode == `CPES_MODE_PULSE);
		case (i_mode)
			`CPES_MODE_TIMER: begin
				// Counting is untouched; only the interrupt edge flips
				next_irq = i_edge_sel ? rise : fall;
			end
			`CPES_MODE_PULSE: begin
				if (!prev_mode_pulse) begin
					next_pulse = ~i_edge_sel;
					next_tick = `CPES_ZERO16;
				end else if (tick + `CPES_ONE16 >= i_half) begin
					next_tick = `CPES_ZERO16;
					next_pulse = ~pulse;
					// Interrupt on the output edge that the switch selects
					next_irq = i_edge_sel ? ~pulse : pulse;
				end else begin
					next_tick = tick + `CPES_ONE16;
				end
			end
			`CPES_MODE_EVENT: begin
				if (i_edge_sel ? fall : rise) begin
					next_count = count + `CPES_ONE16;
				end
				next_irq = i_edge_sel ? rise : fall;
			end
			`CPES_MODE_WIDTH: begin
				// Time the selected level; latch it when that level ends
				if (i_pin == ~i_edge_sel) begin
					next_run = run + `CPES_ONE16;
				end else if (i_edge_sel ? rise : fall) begin
					next_width = run;
					next_run = `CPES_ZERO16;
					next_irq = 1'b1;
				end else begin
					next_run = `CPES_ZERO16;
				end
			end
			default: begin
				next_irq = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			pin_q <= 1'b0;
			pulse <= 1'b0;
			tick <= `CPES_ZERO16;
			count <= `CPES_ZERO16;
			width <= `CPES_ZERO16;
			run <= `CPES_ZERO16;
			o_irq_event <= 1'b0;
			prev_mode_pulse <= 1'b0;
		end else begin
			pin_q <= next_pin_q;
			pulse <= next_pulse;
			tick <= next_tick;
			count <= next_count;
			width <= next_width;
			run <= next_run;
			o_irq_event <= next_irq;
			prev_mode_pulse <= next_prev_mode_pulse;
		end
	end

	assign o_pulse = pulse;
	assign o_count = count;
	assign o_width = width;

	AST_TIMER_FALL: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_TIMER && !i_edge_sel && pin_q && !i_pin) |=> o_irq_event)
		else $error("timer mode falling edge gave no interrupt");
	AST_TIMER_RISE: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_TIMER && i_edge_sel && !pin_q && i_pin) |=> o_irq_event)
		else $error("timer mode rising edge gave no interrupt");
	AST_PULSE_START_H: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_PULSE && !prev_mode_pulse && !i_edge_sel) |=> o_pulse)
		else $error("pulse output did not start high");
	AST_PULSE_START_L: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_PULSE && !prev_mode_pulse && i_edge_sel) |=> !o_pulse)
		else $error("pulse output did not start low");
	AST_PULSE_IRQ_EDGE: assert property (@(posedge i_clock)
		disable iff (i_reset)
		(o_irq_event && $past(i_mode) == `CPES_MODE_PULSE && $past(prev_mode_pulse))
		|-> (o_pulse == $past(i_edge_sel)))
		else $error("pulse interrupt on wrong output edge");
	AST_EVENT_COUNT: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_EVENT && (i_edge_sel ? fall : rise))
		|=> o_count == $past(count) + `CPES_ONE16)
		else $error("event edge not counted");
	AST_EVENT_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_EVENT && !(i_edge_sel ? fall : rise)) |=> $stable(o_count))
		else $error("event count moved without its edge");
	AST_WIDTH_HIGH: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_WIDTH && !i_edge_sel && fall)
		|=> (o_irq_event && o_width == $past(run)))
		else $error("high width not latched on falling edge");
	AST_WIDTH_LOW: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_mode == `CPES_MODE_WIDTH && i_edge_sel && rise)
		|=> (o_irq_event && o_width == $past(run)))
		else $error("low width not latched on rising edge");
endmodule
`default_nettype wire

// file: src/cpes_top.sv
// Two-timer counter pin edge select block with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cpes_cfg.svh"
module cpes_top (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [15:0] o_rdata,
	input wire logic i_counter_pin_a,
	input wire logic i_counter_pin_b,
	output logic o_counter_pin_a,
	output logic o_counter_pin_a_oe,
	output logic o_counter_pin_b,
	output logic o_counter_pin_b_oe,
	output logic o_irq
);
	// Mode: [1:0] mode a, [2] edge a, [5:4] mode b, [6] edge b
	logic [7:0] mode;
	logic [1:0] status;
	logic [1:0] mask;
	logic [15:0] half;
	logic [15:0] rdata;
	logic irq;
	logic [7:0] next_mode;
	logic [1:0] next_status;
	logic [1:0] next_mask;
	logic [15:0] next_half;
	logic [15:0] next_rdata;
	logic next_irq;
	logic [1:0] evt;
	logic [1:0] pulse;
	logic [15:0] count [2];
	logic [15:0] width [2];
	logic [1:0] pin;
	logic pa;
	logic pb;
	logic pa_oe;
	logic pb_oe;
	logic [1:0] was_pulse;
	logic [1:0] next_was_pulse;

	assign pin[0] = i_counter_pin_a;
	assign pin[1] = i_counter_pin_b;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			cpes_channel u_chan (
				.i_clock(i_clock),
				.i_reset(i_reset),
				.i_mode(mode[`CPES_CHAN_STRIDE*g +: 2]),
				.i_edge_sel(mode[`CPES_CHAN_STRIDE*g+`CPES_EDGE_POS]),
				.i_pin(pin[g]),
				.i_half(half),
				.o_irq_event(evt[g]),
				.o_pulse(pulse[g]),
				.o_count(count[g]),
				.o_width(width[g])
			);
		end
	endgenerate

	always_comb begin
		next_mode = mode;
		next_mask = mask;
		next_half = half;
		next_rdata = `CPES_ZERO16;
		next_status = status;
		if (i_write) begin
			case (i_addr)
				`CPES_ADDR_MODE: next_mode = i_wdata[7:0];
				`CPES_ADDR_MASK: next_mask = i_wdata[1:0];
				`CPES_ADDR_HALF: next_half = i_wdata;
				default: next_half = half;
			endcase
		end
		if (i_read) begin
			case (i_addr)
				`CPES_ADDR_MODE: next_rdata = {`CPES_ZERO8, mode};
				`CPES_ADDR_STATUS: next_rdata = {`CPES_ZERO14, status};
				`CPES_ADDR_MASK: next_rdata = {`CPES_ZERO14, mask};
				`CPES_ADDR_COUNT_A: next_rdata = count[0];
				`CPES_ADDR_COUNT_B: next_rdata = count[1];
				`CPES_ADDR_WIDTH_A: next_rdata = width[0];
				`CPES_ADDR_WIDTH_B: next_rdata = width[1];
				`CPES_ADDR_HALF: next_rdata = half;
				default: next_rdata = `CPES_ZERO16;
			endcase
			// Read clears status, but a new event in the same cycle survives
			if (i_addr == `CPES_ADDR_STATUS) begin
				next_status = `CPES_ZERO2;
			end
		end
		next_status = next_status | evt;
		next_irq = |(next_status & next_mask);
		// Drive the pin only in pulse output mode
		pa_oe = (next_mode[`CPES_MODE_A] == `CPES_MODE_PULSE);
		pb_oe = (next_mode[`CPES_MODE_B] == `CPES_MODE_PULSE);
		// The channel loads its start level a cycle after entering pulse mode;
		// until then the pin shows that level itself rather than a stale one
		next_was_pulse[0] = (mode[`CPES_MODE_A] == `CPES_MODE_PULSE);
		next_was_pulse[1] = (mode[`CPES_MODE_B] == `CPES_MODE_PULSE);
		pa = (next_was_pulse[0] && was_pulse[0]) ? pulse[0] : ~next_mode[`CPES_EDGE_A];
		pb = (next_was_pulse[1] && was_pulse[1]) ? pulse[1] : ~next_mode[`CPES_EDGE_B];
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			mode <= `CPES_MODE_RESET;
			status <= `CPES_ZERO2;
			mask <= `CPES_ZERO2;
			was_pulse <= `CPES_ZERO2;
			half <= `CPES_HALF_RESET;
			rdata <= `CPES_ZERO16;
			irq <= 1'b0;
			o_counter_pin_a <= 1'b0;
			o_counter_pin_b <= 1'b0;
			o_counter_pin_a_oe <= 1'b0;
			o_counter_pin_b_oe <= 1'b0;
		end else begin
			mode <= next_mode;
			status <= next_status;
			mask <= next_mask;
			half <= next_half;
			rdata <= next_rdata;
			irq <= next_irq;
			was_pulse <= next_was_pulse;
			o_counter_pin_a <= pa;
			o_counter_pin_b <= pb;
			o_counter_pin_a_oe <= pa_oe;
			o_counter_pin_b_oe <= pb_oe;
		end
	end

	assign o_rdata = rdata;
	assign o_irq = irq;

	AST_PIN_START_A: assert property (@(posedge i_clock)
		disable iff (i_reset)
		$rose(o_counter_pin_a_oe) |-> (o_counter_pin_a == ~mode[`CPES_EDGE_A]))
		else $error("pin a did not start at its selected level");
	AST_PIN_START_B: assert property (@(posedge i_clock)
		disable iff (i_reset)
		$rose(o_counter_pin_b_oe) |-> (o_counter_pin_b == ~mode[`CPES_EDGE_B]))
		else $error("pin b did not start at its selected level");
endmodule
`default_nettype wire

// file: verification/cpes_pin_src.sv
// Signal source standing on the two counter pins
`timescale 1ns/1ps
`default_nettype none
module cpes_pin_src (
	input wire logic i_clock,
	output logic o_pin_a,
	output logic o_pin_b
);
	initial begin
		o_pin_a = 1'b0;
		o_pin_b = 1'b0;
	end
	// New level lands just after an edge and holds for the given cycle count
	task automatic drive(input int ch, input logic lvl, input int hold);
		@(posedge i_clock);
		if (ch == 1) begin
			o_pin_b <= lvl;
		end else begin
			o_pin_a <= lvl;
		end
		repeat (hold - 1) @(posedge i_clock);
	endtask
endmodule
`default_nettype wire

// file: verification/test_counter_pin_edge_select.sv
// Self-checking bench for the counter pin edge select block
`timescale 1ns/1ps
`default_nettype none
`include "cpes_cfg.svh"
module test_counter_pin_edge_select;
	logic i_clock, i_reset, i_write, i_read, src_a, src_b, o_a, o_b, oe_a, oe_b, o_irq;
	logic [3:0] i_addr;
	logic [15:0] i_wdata, o_rdata, junk;
	int error_cnt = 0;
	int cmp_count = 0;
	// Shared pin: the block's output wins while it drives
	wire pin_a = oe_a ? o_a : src_a;
	wire pin_b = oe_b ? o_b : src_b;
	cpes_top u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
		.i_counter_pin_a(pin_a), .i_counter_pin_b(pin_b), .o_counter_pin_a(o_a),
		.o_counter_pin_a_oe(oe_a), .o_counter_pin_b(o_b), .o_counter_pin_b_oe(oe_b),
		.o_irq(o_irq));
	cpes_pin_src u_src (.i_clock(i_clock), .o_pin_a(src_a), .o_pin_b(src_b));
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk_val(d, exp);
	endtask
	task automatic edge_case(input int ch, input logic [1:0] m, input logic e);
		logic [15:0] c0;
		wr(`CPES_ADDR_MODE, 16'({e, m}) << (4 * ch));
		u_src.drive(ch, e, 6);
		rd(`CPES_ADDR_STATUS, c0);
		rd(4'(`CPES_ADDR_COUNT_A + ch), c0);
		// Leading edge must stay silent; held ten cycles for the width figure
		u_src.drive(ch, !e, 10);
		chk_bit(o_irq, 1'b0);
		u_src.drive(ch, e, 6);
		chk_bit(o_irq, 1'b1);
		chk_reg(`CPES_ADDR_STATUS, 16'(1 << ch));
		chk_bit(o_irq, 1'b0);
		chk_reg(4'(`CPES_ADDR_COUNT_A + ch), c0 + 16'(m == `CPES_MODE_EVENT));
		if (m == `CPES_MODE_WIDTH) begin
			chk_reg(4'(`CPES_ADDR_WIDTH_A + ch), 16'h000A);
		end
	endtask
	task automatic pulse_case(input int ch, input logic e);
		wr(`CPES_ADDR_MODE, 16'({e, `CPES_MODE_PULSE}) << (4 * ch));
		// The first driven cycle must already carry the start level
		#1;
		chk_bit(ch == 1 ? oe_b : oe_a, 1'b1);
		chk_bit(ch == 1 ? o_b : o_a, !e);
		repeat (2) @(posedge i_clock);
		#1;
		chk_bit(ch == 1 ? oe_b : oe_a, 1'b1);
		chk_bit(ch == 1 ? o_b : o_a, !e);
		rd(`CPES_ADDR_STATUS, junk);
		chk_reg(`CPES_ADDR_STATUS, 16'h0000);
		repeat (12) @(posedge i_clock);
		chk_reg(`CPES_ADDR_STATUS, 16'(1 << ch));
	endtask
	initial begin
		#500000;
		error_cnt++;
		conclude();
	end
	initial begin
		i_reset = 1'b1;
		i_write = 1'b0;
		i_read = 1'b0;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		repeat (12) @(posedge i_clock);
		i_reset <= 1'b0;
		chk_reg(`CPES_ADDR_MODE, 16'h0000);
		chk_reg(`CPES_ADDR_MASK, 16'h0000);
		chk_reg(`CPES_ADDR_HALF, 16'h0010);
		chk_reg(4'hF, 16'h0000);
		wr(`CPES_ADDR_MASK, 16'h0003);
		// Short half period keeps the pulse cases brief
		wr(`CPES_ADDR_HALF, 16'h0008);
		for (int ch = 0; ch < 2; ch++) begin
			for (int e = 0; e < 2; e++) begin
				edge_case(ch, `CPES_MODE_TIMER, e[0]);
				edge_case(ch, `CPES_MODE_EVENT, e[0]);
				edge_case(ch, `CPES_MODE_WIDTH, e[0]);
				pulse_case(ch, e[0]);
			end
		end
		// Masked channel: status still latches but the line stays quiet
		wr(`CPES_ADDR_MODE, 16'h0000);
		wr(`CPES_ADDR_MASK, 16'h0002);
		u_src.drive(0, 1'b1, 6);
		rd(`CPES_ADDR_STATUS, junk);
		u_src.drive(0, 1'b0, 6);
		chk_bit(o_irq, 1'b0);
		chk_reg(`CPES_ADDR_STATUS, 16'h0001);
		conclude();
	end
endmodule
`default_nettype wire
